// *** design/osd_pkg.sv ***
// constants and carrier types for the serial command decoder
// Functional notes
// - commands arrive as 8-bit units; first unit code 7..4, data 3..0
// - latched command code applies to later units until next first unit
// - after char-write code, every following unit is character data
// - while enable is high the write-address command is current
// - code 1000 sets row (first 3..0) and column (second 4..0)
// - code 1001 writes characters: code in 6..0, attribute in bit 7
// - code 1010: vertical height selects, vertical start, crystal frequency select
// - code 1011: horizontal width selects, horizontal start, dot clock source
// - code 1100: test, erase, osc stop, soft reset; blanking, blink, reverse, display
// - code 1101: standard, non-interlace, internal sync; background, burst, phase
// - code 1110: output modes, line count, mute; acquire and loss counts
// - code 1111: four control bits; second unit ignored
// - shifted data accepted only while enable is low
// - clock-mode strap high selects external clock, low selects crystal
// - during pin reset composite sync output carries crystal clock, not soft reset
// - sync-detect output high on sync; pixel clock during pin reset only
// - standard strap high forces PAL-M, low uses command field
// - vertical sync strap low accepts vertical sync input, high ignores it
// - display grid 24 columns by 12 rows, 288 characters of 12x18
// - character-write mode persists until enable returns high
// - pin reset clears every command setting to zero
package osd_pkg;
  localparam int          UNIT_BITS    = 8;
  localparam logic [3:0]  CODE_ADDR    = 4'h8;
  localparam logic [3:0]  CODE_CHAR    = 4'h9;
  localparam logic [3:0]  CODE_VERT    = 4'ha;
  localparam logic [3:0]  CODE_HORIZ   = 4'hb;
  localparam logic [3:0]  CODE_DCTLA   = 4'hc;
  localparam logic [3:0]  CODE_DCTLB   = 4'hd;
  localparam logic [3:0]  CODE_SYNC    = 4'he;
  localparam logic [3:0]  CODE_DCTLC   = 4'hf;
  localparam int          FIRST_BIT    = 7;
  localparam int          COLS         = 24;
  localparam int          ROWS         = 12;
  localparam logic [1:0]  STD_PALM     = 2'h1;
  localparam int          UNIT_TIME_NS = 4200;
  localparam int          CLK_NS       = 100;
  localparam int          UNIT_CYCLES  = (UNIT_TIME_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [3:0] row;
    logic [4:0] col;
  } osd_addr_s;

  typedef struct packed {
    logic       attr;
    logic [6:0] code;
  } osd_char_s;

  typedef struct packed {
    logic [3:0] vsize;
    logic [5:0] vstart;
    logic       crystal_freq_select;
    logic [3:0] hsize;
    logic [5:0] hstart;
    logic       dot_clock_source;
  } osd_pos_s;

  typedef struct packed {
    logic       test_mode_bit;
    logic       ram_erase;
    logic       osc_stop_enable;
    logic       soft_reset;
    logic [2:0] blank;
    logic [1:0] blink;
    logic       reverse_video;
    logic       display_on;
    logic [1:0] std_sel;
    logic       non_interlace;
    logic       int_sync;
    logic       background_off;
    logic       burst_off;
    logic [2:0] bg_phase;
    logic [1:0] out_mode;
    logic       line_count_sel;
    logic       video_mute;
    logic [2:0] acq_count;
    logic [3:0] loss_count;
    logic [3:0] ctl_c;
  } osd_ctl_s;

  typedef enum logic [1:0] {
    ST_FIRST  = 2'b00,
    ST_SECOND = 2'b01,
    ST_CHAR   = 2'b11
  } osd_state_e;
endpackage : osd_pkg

// *** design/osd_shift_rx.sv ***
// serial unit receiver: synchronises pins, shifts lsb first
`timescale 1ns/1ns
module osd_shift_rx (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  input  wire logic       i_serial_in,
  output logic            o_cs_n,
  output logic            o_unit_vld,
  output logic [7:0]      o_unit
);
  import osd_pkg::*;

  logic [1:0] cs_sync_r, ck_sync_r, dt_sync_r;
  logic       ck_prev_r, ck_prev_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic       vld_r, vld_nxt;
  logic [7:0] unit_r, unit_nxt;
  logic       rise;

  // two-stage synchronisers; only stage two is read
  always_ff @(posedge i_ref_clk) begin
    cs_sync_r <= {cs_sync_r[0], i_cs_n};
    ck_sync_r <= {ck_sync_r[0], i_sclk};
    dt_sync_r <= {dt_sync_r[0], i_serial_in};
  end

  assign rise = ck_sync_r[1] & ~ck_prev_r;

  // shift next values
  always_comb begin
    ck_prev_nxt = ck_sync_r[1];
    sh_nxt      = sh_r;
    cnt_nxt     = cnt_r;
    vld_nxt     = 1'b0;
    unit_nxt    = unit_r;
    if (cs_sync_r[1]) begin
      // enable high drops any partial unit
      cnt_nxt = 3'h0;
    end else if (rise) begin
      sh_nxt  = {dt_sync_r[1], sh_r[7:1]};
      cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == 3'h7) begin
        vld_nxt  = 1'b1;
        unit_nxt = {dt_sync_r[1], sh_r[7:1]};
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ck_prev_r <= 1'b1;
      sh_r      <= 8'h00;
      cnt_r     <= 3'h0;
      vld_r     <= 1'b0;
      unit_r    <= 8'h00;
    end else begin
      ck_prev_r <= ck_prev_nxt;
      sh_r      <= sh_nxt;
      cnt_r     <= cnt_nxt;
      vld_r     <= vld_nxt;
      unit_r    <= unit_nxt;
    end
  end

  assign o_cs_n     = cs_sync_r[1];
  assign o_unit_vld = vld_r;
  assign o_unit     = unit_r;
endmodule : osd_shift_rx

// *** design/osd_serial_cmd.sv ***
// command decoder top: latches codes, decodes settings, straps, reset outputs
`timescale 1ns/1ns
module osd_serial_cmd (
  input  wire logic            i_ref_clk,
  input  wire logic            i_rstn,
  input  wire logic            i_cs_n,
  input  wire logic            i_sclk,
  input  wire logic            i_serial_in,
  input  wire logic            i_clock_mode_strap,
  input  wire logic            i_standard_strap,
  input  wire logic            i_vsync_use_strap,
  input  wire logic            i_vertical_sync_in,
  input  wire logic            i_crystal_clk,
  input  wire logic            i_pixel_clk,
  input  wire logic            i_comp_sync,
  input  wire logic            i_sync_found,
  output osd_pkg::osd_addr_s   o_addr,
  output osd_pkg::osd_char_s   o_char,
  output logic                 o_char_we,
  output osd_pkg::osd_pos_s    o_pos,
  output osd_pkg::osd_ctl_s    o_ctl,
  output logic [1:0]           o_std_eff,
  output logic                 o_ext_clk_sel,
  output logic                 o_vsync_eff,
  output logic                 o_composite_sync_out,
  output logic                 o_sync_detect
);
  import osd_pkg::*;

  logic       cs_n;
  logic       uvld;
  logic [7:0] unit;

  osd_shift_rx u_rx (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_cs_n      (i_cs_n),
    .i_sclk      (i_sclk),
    .i_serial_in (i_serial_in),
    .o_cs_n      (cs_n),
    .o_unit_vld  (uvld),
    .o_unit      (unit)
  );

  // two-stage sync of straps and pin-level signals
  logic [1:0] s_clk_r, s_std_r, s_vus_r, s_vsi_r, s_xc_r, s_pc_r, s_cs_r, s_sf_r;
  always_ff @(posedge i_ref_clk) begin
    s_clk_r <= {s_clk_r[0], i_clock_mode_strap};
    s_std_r <= {s_std_r[0], i_standard_strap};
    s_vus_r <= {s_vus_r[0], i_vsync_use_strap};
    s_vsi_r <= {s_vsi_r[0], i_vertical_sync_in};
    s_xc_r  <= {s_xc_r[0], i_crystal_clk};
    s_pc_r  <= {s_pc_r[0], i_pixel_clk};
    s_cs_r  <= {s_cs_r[0], i_comp_sync};
    s_sf_r  <= {s_sf_r[0], i_sync_found};
  end

  function automatic logic is_first(input logic [7:0] u);
    is_first = u[FIRST_BIT];
  endfunction : is_first

  osd_state_e st_r, st_nxt;
  logic [3:0] code_r, code_nxt;
  osd_addr_s  addr_r, addr_nxt;
  osd_char_s  char_r, char_nxt;
  logic       we_r, we_nxt;
  osd_pos_s   pos_r, pos_nxt;
  osd_ctl_s   ctl_r, ctl_nxt;

  // command sequencing and field decode
  always_comb begin
    st_nxt    = st_r;
    code_nxt  = code_r;
    addr_nxt  = addr_r;
    char_nxt  = char_r;
    we_nxt    = 1'b0;
    pos_nxt   = pos_r;
    ctl_nxt   = ctl_r;
    if (cs_n) begin
      code_nxt = CODE_ADDR;
      st_nxt   = ST_FIRST;
    end else if (uvld) begin
      case (st_r)
        ST_CHAR: begin
          char_nxt = unit;
          we_nxt   = 1'b1;
        end
        ST_FIRST, ST_SECOND: begin
          if (is_first(unit)) begin
            code_nxt  = unit[7:4];
            st_nxt    = (unit[7:4] == CODE_CHAR) ? ST_CHAR : ST_SECOND;
            case (unit[7:4])
              CODE_ADDR:   addr_nxt.row = unit[3:0];
              CODE_VERT:   pos_nxt.vsize = unit[3:0];
              CODE_HORIZ:  pos_nxt.hsize = unit[3:0];
              CODE_DCTLA: begin
                {ctl_nxt.test_mode_bit, ctl_nxt.ram_erase,
                 ctl_nxt.osc_stop_enable, ctl_nxt.soft_reset} = unit[3:0];
              end
              CODE_DCTLB: begin
                {ctl_nxt.std_sel, ctl_nxt.non_interlace, ctl_nxt.int_sync} = unit[3:0];
              end
              CODE_SYNC: begin
                {ctl_nxt.out_mode, ctl_nxt.line_count_sel, ctl_nxt.video_mute} = unit[3:0];
              end
              CODE_DCTLC:  ctl_nxt.ctl_c = unit[3:0];
              default: begin
              end
            endcase
          end else begin
            case (code_r)
              CODE_ADDR:  addr_nxt.col = unit[4:0];
              CODE_VERT:  {pos_nxt.crystal_freq_select, pos_nxt.vstart} = unit[6:0];
              CODE_HORIZ: {pos_nxt.dot_clock_source, pos_nxt.hstart} = unit[6:0];
              CODE_DCTLA: begin
                {ctl_nxt.blank, ctl_nxt.blink, ctl_nxt.reverse_video,
                 ctl_nxt.display_on} = unit[6:0];
              end
              CODE_DCTLB: begin
                {ctl_nxt.background_off, ctl_nxt.burst_off, ctl_nxt.bg_phase} = unit[4:0];
              end
              CODE_SYNC:  {ctl_nxt.acq_count, ctl_nxt.loss_count} = unit[6:0];
              CODE_DCTLC: begin
              end
              default: begin
              end
            endcase
          end
        end
        default: st_nxt = ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_r    <= ST_FIRST;
      code_r  <= CODE_ADDR;
      addr_r  <= '0;
      char_r  <= '0;
      we_r    <= 1'b0;
      pos_r   <= '0;
      ctl_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      code_r  <= code_nxt;
      addr_r  <= addr_nxt;
      char_r  <= char_nxt;
      we_r    <= we_nxt;
      pos_r   <= pos_nxt;
      ctl_r   <= ctl_nxt;
    end
  end

  logic [1:0] std_r, std_nxt;
  logic       extc_r, extc_nxt, vs_r, vs_nxt, csy_r, csy_nxt, sd_r, sd_nxt;

  // strap handling and reset-time outputs
  always_comb begin
    std_nxt  = s_std_r[1] ? STD_PALM : ctl_r.std_sel;
    extc_nxt = s_clk_r[1];
    vs_nxt   = s_vus_r[1] ? 1'b0 : s_vsi_r[1];
    csy_nxt  = !i_rstn ? s_xc_r[1] : s_cs_r[1];
    sd_nxt   = !i_rstn ? s_pc_r[1] : s_sf_r[1];
  end

  // reset does not touch these so pin-reset clocks pass through
  always_ff @(posedge i_ref_clk) begin
    std_r  <= std_nxt;
    extc_r <= extc_nxt;
    vs_r   <= vs_nxt;
    csy_r  <= csy_nxt;
    sd_r   <= sd_nxt;
  end

  // grid bounds are the memory's job; fields sized to 24x12
  assign o_addr               = addr_r;
  assign o_char               = char_r;
  assign o_char_we            = we_r;
  assign o_pos                = pos_r;
  assign o_ctl                = ctl_r;
  assign o_std_eff            = std_r;
  assign o_ext_clk_sel        = extc_r;
  assign o_vsync_eff          = vs_r;
  assign o_composite_sync_out = csy_r;
  assign o_sync_detect        = sd_r;
endmodule : osd_serial_cmd

// *** bench/osd_serial_cmd_chk.sv ***
// port assertions for the serial command decoder
`timescale 1ns/1ns
module osd_serial_cmd_chk (
  input wire logic              i_ref_clk,
  input wire logic              i_rstn,
  input wire logic              i_cs_n,
  input wire logic              i_clock_mode_strap,
  input wire logic              i_standard_strap,
  input wire logic              i_vsync_use_strap,
  input wire logic              i_vertical_sync_in,
  input wire logic              i_comp_sync,
  input wire logic              i_sync_found,
  input wire osd_pkg::osd_addr_s o_addr,
  input wire logic              o_char_we,
  input wire osd_pkg::osd_pos_s  o_pos,
  input wire osd_pkg::osd_ctl_s  o_ctl,
  input wire logic [1:0]        o_std_eff,
  input wire logic              o_ext_clk_sel,
  input wire logic              o_vsync_eff,
  input wire logic              o_composite_sync_out,
  input wire logic              o_sync_detect
);
  import osd_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // straps pass a two-stage sync plus one register
  chk_clk_strap: assert property (o_ext_clk_sel == $past(i_clock_mode_strap, 3))
    else $error("clock strap not mirrored");
  chk_vsync_gate: assert property (
    o_vsync_eff == ($past(i_vsync_use_strap, 3) ? 1'b0 : $past(i_vertical_sync_in, 3)))
    else $error("vsync gating wrong");
  chk_std_force: assert property ($past(i_standard_strap, 3) |-> o_std_eff == STD_PALM)
    else $error("standard not forced");
  chk_we_pulse: assert property (o_char_we |=> !o_char_we)
    else $error("char strobe too long");
  chk_we_cs_low: assert property (o_char_we |-> $past(i_cs_n, 8) == 1'b0)
    else $error("char written without enable");
  chk_cs_idle: assert property (
    i_cs_n [*8] |-> !o_char_we && $stable(o_ctl) && $stable(o_pos))
    else $error("activity with enable high");
  // reset itself is the cause here, so no disable
  chk_pin_clear: assert property (disable iff (1'b0)
    !i_rstn |=> o_ctl == '0 && o_pos == '0 && o_addr == '0 && !o_char_we)
    else $error("reset did not clear");
  chk_sync_pass: assert property ((i_rstn && i_sync_found) [*4] |-> o_sync_detect)
    else $error("sync detect not passed");
  chk_csync_pass: assert property (
    (i_rstn && !i_comp_sync) [*4] |-> !o_composite_sync_out)
    else $error("composite sync not passed");
  cov_char: cover property (o_char_we);
  cov_soft: cover property (o_ctl.soft_reset);
  cov_rst_clk: cover property (disable iff (1'b0) !i_rstn && o_composite_sync_out);
endmodule : osd_serial_cmd_chk

bind osd_serial_cmd osd_serial_cmd_chk chk_u (.i_ref_clk, .i_rstn, .i_cs_n,
  .i_clock_mode_strap, .i_standard_strap, .i_vsync_use_strap, .i_vertical_sync_in,
  .i_comp_sync, .i_sync_found, .o_addr, .o_char_we, .o_pos, .o_ctl, .o_std_eff,
  .o_ext_clk_sel, .o_vsync_eff, .o_composite_sync_out, .o_sync_detect);

// *** bench/osd_host_model.sv ***
// host side of the three-wire serial command link
`timescale 1ns/1ns
module osd_host_model (
  input  wire logic i_ref_clk,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdata
);
  // idle: pulled-up lines high, serial clock still
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_sdata = 1'b1;
  end
  // moves just after a reference edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic start_frame();
    o_cs_n = 1'b0;
    tick(4);
  endtask : start_frame
  // 6.4 us a unit, above the floor
  task automatic send_unit(input logic [7:0] u);
    for (int i = 0; i < 8; i++) begin
      o_sclk = 1'b0;
      o_sdata = u[i];
      tick(4);
      o_sclk = 1'b1;
      tick(4);
    end
  endtask : send_unit
  // enable high for over 1 us between frames
  task automatic end_frame();
    o_cs_n = 1'b1;
    o_sdata = 1'b1;
    tick(12);
  endtask : end_frame
endmodule : osd_host_model

// *** bench/osd_serial_cmd_tb.sv ***
// self-checking bench for the serial command decoder
`timescale 1ns/1ns
module osd_serial_cmd_tb;
  import osd_pkg::*;
  logic i_ref_clk, i_rstn, i_cs_n, i_sclk, i_serial_in, i_comp_sync, i_sync_found;
  logic i_clock_mode_strap, i_standard_strap, i_vsync_use_strap, i_vertical_sync_in;
  logic o_char_we, o_ext_clk_sel, o_vsync_eff, o_composite_sync_out, o_sync_detect, lc, ls;
  logic [1:0] o_std_eff, xp = 2'h0;
  logic [3:0] cur;
  logic [7:0] u;
  logic [31:0] w, seed = 32'h00009d05;
  logic chmode;
  osd_addr_s o_addr, e_addr;
  osd_char_s o_char, cq[$];
  osd_pos_s o_pos, e_pos;
  osd_ctl_s o_ctl, e_ctl;
  int n_mismatch = 0, n_compared = 0, n_cs, n_sd;
  wire i_crystal_clk = xp[0];
  wire i_pixel_clk = xp[1];
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  osd_host_model host_u (.i_ref_clk, .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_sdata(i_serial_in));
  osd_serial_cmd dut_u (.i_ref_clk, .i_rstn, .i_cs_n, .i_sclk, .i_serial_in,
    .i_clock_mode_strap, .i_standard_strap, .i_vsync_use_strap, .i_vertical_sync_in,
    .i_crystal_clk, .i_pixel_clk, .i_comp_sync, .i_sync_found, .o_addr, .o_char, .o_char_we,
    .o_pos, .o_ctl, .o_std_eff, .o_ext_clk_sel, .o_vsync_eff, .o_composite_sync_out,
    .o_sync_detect);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp_set(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_set
  // an empty queue means the strobe was not expected
  task automatic cmp_chr(input osd_char_s got);
    if (cq.size() == 0) cmp_set(64'(got), {64{1'bx}});
    else cmp_set(64'(got), 64'(cq.pop_front()));
  endtask : cmp_chr
  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // reference model of the decoder, fed each unit before it is shifted
  // field decode
  task automatic apply(input logic [7:0] v);
    if (chmode) cq.push_back(v);
    else if (v[7]) begin
      cur = v[7:4];
      chmode = (cur == CODE_CHAR);
      case (cur)
        CODE_ADDR: e_addr.row = v[3:0];
        CODE_VERT: e_pos.vsize = v[3:0];
        CODE_HORIZ: e_pos.hsize = v[3:0];
        CODE_DCTLA: {e_ctl.test_mode_bit, e_ctl.ram_erase, e_ctl.osc_stop_enable,
                     e_ctl.soft_reset} = v[3:0];
        CODE_DCTLB: {e_ctl.std_sel, e_ctl.non_interlace, e_ctl.int_sync} = v[3:0];
        CODE_SYNC: {e_ctl.out_mode, e_ctl.line_count_sel, e_ctl.video_mute} = v[3:0];
        CODE_DCTLC: e_ctl.ctl_c = v[3:0];
        default: ;
      endcase
    end else case (cur)
      CODE_ADDR: e_addr.col = v[4:0];
      CODE_VERT: {e_pos.crystal_freq_select, e_pos.vstart} = v[6:0];
      CODE_HORIZ: {e_pos.dot_clock_source, e_pos.hstart} = v[6:0];
      CODE_DCTLA: {e_ctl.blank, e_ctl.blink, e_ctl.reverse_video, e_ctl.display_on} = v[6:0];
      CODE_DCTLB: {e_ctl.background_off, e_ctl.burst_off, e_ctl.bg_phase} = v[4:0];
      CODE_SYNC: {e_ctl.acq_count, e_ctl.loss_count} = v[6:0];
      default: ;
    endcase
  endtask : apply
  task automatic check_all();
    cmp_set(64'(o_ctl), 64'(e_ctl));
    cmp_set(64'(o_pos), 64'(e_pos));
    cmp_set(64'(o_addr), 64'(e_addr));
    cmp_set(64'(o_std_eff), 64'(i_standard_strap ? STD_PALM : e_ctl.std_sel));
    cmp_set(64'(o_ext_clk_sel), 64'(i_clock_mode_strap));
    cmp_set(64'(o_vsync_eff), 64'(!i_vsync_use_strap && i_vertical_sync_in));
    cmp_set(64'(o_composite_sync_out), 64'(i_comp_sync));
    cmp_set(64'(o_sync_detect), 64'(i_sync_found));
  endtask : check_all
  // both slow clocks must show through while the pin is low
  task automatic do_reset();
    i_rstn = 1'b0;
    n_cs = 0;
    n_sd = 0;
    host_u.tick(12);
    cmp_set(64'(n_cs > 4 && n_sd > 2), 64'h1);
    i_rstn = 1'b1;
    {e_ctl, e_pos, e_addr} = '0;
    cq.delete();
    host_u.tick(4);
    check_all();
  endtask : do_reset
  // slow clocks and the char strobe monitor
  always @(posedge i_ref_clk) begin
    #1 xp = xp + 2'h1;
  end
  always @(posedge i_ref_clk) begin
    if (o_char_we === 1'b1) cmp_chr(o_char);
    if (!i_rstn && o_composite_sync_out !== lc) n_cs++;
    if (!i_rstn && o_sync_detect !== ls) n_sd++;
    lc = o_composite_sync_out;
    ls = o_sync_detect;
  end
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {i_rstn, i_clock_mode_strap, i_standard_strap, i_vsync_use_strap} = 4'h0;
    {i_vertical_sync_in, i_comp_sync, i_sync_found} = 3'h0;
    do_reset();
    for (int f = 0; f < 70; f++) begin
      if (f == 35) do_reset();
      w = rnd();
      {i_clock_mode_strap, i_standard_strap, i_vsync_use_strap} = w[12:10];
      {i_vertical_sync_in, i_comp_sync, i_sync_found} = w[15:13];
      // units shifted with enable high must change nothing
      if (w[2:0] == 3'h0) host_u.send_unit(8'(rnd()));
      else begin
        // enable high makes the address command current
        cur = CODE_ADDR;
        chmode = 1'b0;
        host_u.start_frame();
        for (int k = 0; k <= int'(w[4:3]); k++) begin
          u = 8'(rnd());
          if (k == 0) u[7] = ~w[6];
          else u[7] = u[7] & w[9];
          if (k == 0 && w[8:7] == 2'h0) u = {CODE_CHAR, 4'h0};
          apply(u);
          host_u.send_unit(u);
        end
        host_u.end_frame();
      end
      host_u.tick(12);
      check_all();
    end
    cmp_set(64'(cq.size()), 64'h0);
    give_verdict();
  end
endmodule : osd_serial_cmd_tb
